// file: epm_monitor.sv
// Engine protection monitor: contact and measurement protections with persistence timers.
// Assumes engine status and measurements come from logic on sys_clk; contacts are raw pins.
`timescale 1ns/1ps
module epm_monitor
    import epm_pkg::*;
#(
    parameter int SEC_CYCLES = EPM_SEC_CYCLES,
    parameter int SEC_PER_HOUR = EPM_SEC_PER_HOUR
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Register port
    input wire logic [EPM_AW-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // Plant side
    input wire logic [EPM_NUM_DI-1:0] contactPin,
    input wire epm_mode_e opMode,
    input wire epm_eng_s engine,
    input wire epm_meas_s meas,
    input wire logic svcRestore,
    // Anomaly side
    output epm_anom_s anomaly,
    output logic irq
);

    typedef struct packed {
        logic [31:0] preCnt;
        logic secTick;
        logic [EPM_NUM_DI-1:0] diMeta;
        logic [EPM_NUM_DI-1:0] diSync;
        logic [EPM_NUM_DI-1:0][15:0] diFunc;
        logic [EPM_NUM_DI-1:0][15:0] diDelay;
        logic [EPM_NUM_DI-1:0][15:0] diCnt;
        logic [15:0] tmask;
        logic [15:0] maskCnt;
        logic [EPM_NUM_TM-1:0][15:0] tmLvl;
        logic [EPM_NUM_TM-1:0][15:0] tmDly;
        logic [EPM_NUM_TM-1:0][15:0] tmCnt;
        logic [15:0] maintInt;
        epm_act_e maintAct;
        logic installer;
        logic [31:0] secInHour;
        logic [15:0] hours;
        logic svc;
        logic nom24;
        logic pwrOnDone;
        epm_mode_e prevMode;
        logic [EPM_NUM_EV-1:0] live;
        logic [EPM_NUM_EV-1:0] status;
        logic [EPM_NUM_EV-1:0] irqEn;
        logic [31:0] rdata;
    } epm_state_s;

    epm_state_s state_ff;
    epm_state_s nxt_state;

    // Persistence step: restart on a break, saturate at the delay
    function automatic logic [15:0] epm_tmr_step(
        input logic [15:0] cnt,
        input logic cond,
        input logic [15:0] dly,
        input logic tick
    );
        logic [15:0] res;
        res = 16'h0000;
        if (cond)
        begin
            if (cnt >= dly)
                res = dly;
            else if (tick)
                res = cnt + 16'h0001;
            else
                res = cnt;
        end
        return res;
    endfunction : epm_tmr_step

    logic modeOk;
    logic engArmed;
    logic maskDone;
    logic [31:0] nomMv;
    logic [31:0] batScaled;
    logic [EPM_NUM_TM-1:0] tmCond;
    logic [EPM_NUM_TM-1:0] tmTrip;
    logic [EPM_NUM_DI-1:0] diCond;
    logic [EPM_NUM_DI-1:0] diTrip;
    logic [EPM_NUM_DI-1:0] diIsCool;
    logic [EPM_NUM_DI-1:0] diIsOpsd;
    logic [EPM_NUM_DI-1:0] diIsOppa;

    assign modeOk = (opMode == EPM_MODE_MAN) || (opMode == EPM_MODE_AUTO);
    assign engArmed = modeOk && engine.fuelOpen && !engine.startPhase
                      && !engine.stopPhase;
    assign maskDone = (state_ff.maskCnt >= state_ff.tmask);
    assign nomMv = state_ff.nom24 ? EPM_NOM24_MV : EPM_NOM12_MV;
    assign batScaled = 32'(meas.batMv) * EPM_PCT_SCALE;

    // Per-input contact qualification
    generate
        for (genvar gi = 0; gi < EPM_NUM_DI; gi++)
        begin : g_di
            assign diIsCool[gi] = (state_ff.diFunc[gi] == EPM_FN_COOL_SD);
            assign diIsOpsd[gi] = (state_ff.diFunc[gi] == EPM_FN_OILP_SD);
            assign diIsOppa[gi] = (state_ff.diFunc[gi] == EPM_FN_OILP_PA);
            // A zero delay leaves the input unarmed
            assign diCond[gi] = state_ff.diSync[gi] && (state_ff.diDelay[gi] != 16'h0000)
                                && (diIsCool[gi] || diIsOpsd[gi] || diIsOppa[gi])
                                && engArmed && maskDone;
            assign diTrip[gi] = diCond[gi] && (state_ff.diCnt[gi] == state_ff.diDelay[gi]);
        end
    endgenerate

    // Measurement conditions
    always_comb
    begin
        tmCond = '0;
        tmCond[EPM_TM_COOL] = meas.coolAvail && engArmed && maskDone
                              && (meas.coolTemp >= state_ff.tmLvl[EPM_TM_COOL]);
        tmCond[EPM_TM_OILT] = meas.oiltAvail && engArmed && maskDone
                              && (meas.oilTemp >= state_ff.tmLvl[EPM_TM_OILT]);
        tmCond[EPM_TM_OPSD] = meas.oilpAvail && engArmed && maskDone
                              && (meas.oilPress <= state_ff.tmLvl[EPM_TM_OPSD]);
        tmCond[EPM_TM_OPPA] = meas.oilpAvail && engArmed && maskDone
                              && (meas.oilPress <= state_ff.tmLvl[EPM_TM_OPPA]);
        // Percent of nominal: compare bat*100 with pct*nominal to avoid a divider
        tmCond[EPM_TM_BLO] = modeOk && !engine.starterOn
            && (batScaled < 32'(state_ff.tmLvl[EPM_TM_BLO]) * nomMv);
        tmCond[EPM_TM_BHI] = modeOk && !engine.starterOn
            && (batScaled > 32'(state_ff.tmLvl[EPM_TM_BHI]) * nomMv);
        for (int i = 0; i < EPM_NUM_TM; i++)
        begin
            if (state_ff.tmDly[i] == 16'h0000)
                tmCond[i] = 1'b0;
        end
    end

    always_comb
    begin
        for (int i = 0; i < EPM_NUM_TM; i++)
            tmTrip[i] = tmCond[i] && (state_ff.tmCnt[i] == state_ff.tmDly[i]);
    end

    always_comb
    begin
        logic [EPM_NUM_EV-1:0] evSet;
        logic [EPM_NUM_EV-1:0] clrMask;
        logic [31:0] rd;
        logic [7:0] diIdx;
        evSet = '0;
        clrMask = '0;
        rd = 32'h0000_0000;
        diIdx = 8'h00;
        nxt_state = state_ff;

        // One-second tick
        if (state_ff.preCnt >= 32'(SEC_CYCLES - 1))
        begin
            nxt_state.preCnt = 32'h0000_0000;
            nxt_state.secTick = 1'b1;
        end
        else
        begin
            nxt_state.preCnt = state_ff.preCnt + 32'h0000_0001;
            nxt_state.secTick = 1'b0;
        end

        nxt_state.diMeta = contactPin;
        nxt_state.diSync = state_ff.diMeta;

        // Time mask runs from engine start; cleared while the engine is not running
        if (!engine.running)
            nxt_state.maskCnt = 16'h0000;
        else if (state_ff.secTick && !maskDone)
            nxt_state.maskCnt = state_ff.maskCnt + 16'h0001;

        for (int i = 0; i < EPM_NUM_DI; i++)
            nxt_state.diCnt[i] = epm_tmr_step(state_ff.diCnt[i], diCond[i],
                                              state_ff.diDelay[i], state_ff.secTick);
        for (int i = 0; i < EPM_NUM_TM; i++)
            nxt_state.tmCnt[i] = epm_tmr_step(state_ff.tmCnt[i], tmCond[i],
                                              state_ff.tmDly[i], state_ff.secTick);

        // Battery nominal detection at power-on and on each entry to off
        nxt_state.prevMode = opMode;
        nxt_state.pwrOnDone = 1'b1;
        if (!state_ff.pwrOnDone
            || (opMode == EPM_MODE_OFF && state_ff.prevMode != EPM_MODE_OFF))
            nxt_state.nom24 = (32'(meas.batMv) >= EPM_BAT_SPLIT_MV);

        // Saved service flag is restored once, after reset release
        if (!state_ff.pwrOnDone && svcRestore)
            nxt_state.svc = 1'b1;

        // Running hours since the interval was last written
        if (modeOk && engine.running && state_ff.secTick)
        begin
            if (state_ff.secInHour >= 32'(SEC_PER_HOUR - 1))
            begin
                nxt_state.secInHour = 32'h0000_0000;
                if (state_ff.hours != 16'hFFFF)
                    nxt_state.hours = state_ff.hours + 16'h0001;
            end
            else
                nxt_state.secInHour = state_ff.secInHour + 32'h0000_0001;
        end
        if (modeOk && state_ff.maintInt != 16'h0000 && state_ff.hours >= state_ff.maintInt)
            nxt_state.svc = 1'b1;

        // Live anomalies
        nxt_state.live[EPM_EV_COOL_CT] = |(diTrip & diIsCool);
        nxt_state.live[EPM_EV_COOL_MS] = tmTrip[EPM_TM_COOL];
        nxt_state.live[EPM_EV_OILT_MS] = tmTrip[EPM_TM_OILT];
        nxt_state.live[EPM_EV_OPSD_CT] = |(diTrip & diIsOpsd);
        nxt_state.live[EPM_EV_OPSD_MS] = tmTrip[EPM_TM_OPSD];
        nxt_state.live[EPM_EV_OPPA_CT] = |(diTrip & diIsOppa);
        nxt_state.live[EPM_EV_OPPA_MS] = tmTrip[EPM_TM_OPPA];
        nxt_state.live[EPM_EV_BAT_LO] = tmTrip[EPM_TM_BLO];
        nxt_state.live[EPM_EV_BAT_HI] = tmTrip[EPM_TM_BHI];
        nxt_state.live[EPM_EV_SVC] = state_ff.svc;

        // Register writes
        if (regWr)
        begin
            if (regAddr == EPM_REG_CTRL)
                nxt_state.installer = regWdata[EPM_CTRL_INSTALLER];
            else if (regAddr == EPM_REG_TMASK)
                nxt_state.tmask = regWdata[15:0];
            else if (regAddr == EPM_REG_COOL_SD)
            begin
                nxt_state.tmLvl[EPM_TM_COOL] = regWdata[EPM_LVL_LSB +: 16];
                nxt_state.tmDly[EPM_TM_COOL] = regWdata[EPM_DLY_LSB +: 16];
            end
            else if (regAddr == EPM_REG_OILT_SD)
            begin
                nxt_state.tmLvl[EPM_TM_OILT] = regWdata[EPM_LVL_LSB +: 16];
                nxt_state.tmDly[EPM_TM_OILT] = regWdata[EPM_DLY_LSB +: 16];
            end
            else if (regAddr == EPM_REG_OILP_SD)
            begin
                nxt_state.tmLvl[EPM_TM_OPSD] = regWdata[EPM_LVL_LSB +: 16];
                nxt_state.tmDly[EPM_TM_OPSD] = regWdata[EPM_DLY_LSB +: 16];
            end
            else if (regAddr == EPM_REG_OILP_PA)
            begin
                nxt_state.tmLvl[EPM_TM_OPPA] = regWdata[EPM_LVL_LSB +: 16];
                nxt_state.tmDly[EPM_TM_OPPA] = regWdata[EPM_DLY_LSB +: 16];
            end
            else if (regAddr == EPM_REG_BAT_LO)
            begin
                nxt_state.tmLvl[EPM_TM_BLO] = regWdata[EPM_LVL_LSB +: 16];
                nxt_state.tmDly[EPM_TM_BLO] = regWdata[EPM_DLY_LSB +: 16];
            end
            else if (regAddr == EPM_REG_BAT_HI)
            begin
                nxt_state.tmLvl[EPM_TM_BHI] = regWdata[EPM_LVL_LSB +: 16];
                nxt_state.tmDly[EPM_TM_BHI] = regWdata[EPM_DLY_LSB +: 16];
            end
            else if (regAddr == EPM_REG_MAINT_INT)
            begin
                // Any accepted write, even of the same value, restarts the count
                if (state_ff.installer)
                begin
                    nxt_state.maintInt = regWdata[15:0];
                    nxt_state.hours = 16'h0000;
                    nxt_state.secInHour = 32'h0000_0000;
                    nxt_state.svc = 1'b0;
                end
            end
            else if (regAddr == EPM_REG_MAINT_ACT)
            begin
                if (state_ff.installer)
                    nxt_state.maintAct = epm_act_e'(regWdata[1:0]);
            end
            else if (regAddr == EPM_REG_IRQ_CLR)
                clrMask = regWdata[EPM_NUM_EV-1:0];
            else if (regAddr == EPM_REG_IRQ_EN)
                nxt_state.irqEn = regWdata[EPM_NUM_EV-1:0];
            else if (regAddr >= EPM_REG_DI_BASE
                     && regAddr < EPM_REG_DI_BASE + 8'(4 * EPM_NUM_DI)
                     && regAddr[1:0] == 2'b00)
            begin
                diIdx = (regAddr - EPM_REG_DI_BASE) >> 2;
                nxt_state.diFunc[diIdx] = regWdata[EPM_LVL_LSB +: 16];
                nxt_state.diDelay[diIdx] = regWdata[EPM_DLY_LSB +: 16];
            end
        end

        // Sticky status: a new event beats a clear in the same cycle
        evSet = nxt_state.live & ~state_ff.live;
        nxt_state.status = (state_ff.status & ~clrMask) | evSet;

        // Register reads; data stand one cycle after the strobe only
        if (regRd)
        begin
            if (regAddr == EPM_REG_CTRL)
                rd = {31'h0000_0000, state_ff.installer};
            else if (regAddr == EPM_REG_TMASK)
                rd = {16'h0000, state_ff.tmask};
            else if (regAddr == EPM_REG_COOL_SD)
                rd = {state_ff.tmDly[EPM_TM_COOL], state_ff.tmLvl[EPM_TM_COOL]};
            else if (regAddr == EPM_REG_OILT_SD)
                rd = {state_ff.tmDly[EPM_TM_OILT], state_ff.tmLvl[EPM_TM_OILT]};
            else if (regAddr == EPM_REG_OILP_SD)
                rd = {state_ff.tmDly[EPM_TM_OPSD], state_ff.tmLvl[EPM_TM_OPSD]};
            else if (regAddr == EPM_REG_OILP_PA)
                rd = {state_ff.tmDly[EPM_TM_OPPA], state_ff.tmLvl[EPM_TM_OPPA]};
            else if (regAddr == EPM_REG_BAT_LO)
                rd = {state_ff.tmDly[EPM_TM_BLO], state_ff.tmLvl[EPM_TM_BLO]};
            else if (regAddr == EPM_REG_BAT_HI)
                rd = {state_ff.tmDly[EPM_TM_BHI], state_ff.tmLvl[EPM_TM_BHI]};
            else if (regAddr == EPM_REG_MAINT_INT)
                rd = {16'h0000, state_ff.maintInt};
            else if (regAddr == EPM_REG_MAINT_ACT)
                rd = {30'h0000_0000, state_ff.maintAct};
            else if (regAddr == EPM_REG_STATUS)
            begin
                rd[EPM_NUM_EV-1:0] = state_ff.status;
                rd[EPM_ST_NOM24] = state_ff.nom24;
                rd[EPM_ST_MASKDONE] = maskDone;
                rd[EPM_ST_SVC] = state_ff.svc;
            end
            else if (regAddr == EPM_REG_IRQ_EN)
                rd = {22'h00_0000, state_ff.irqEn};
            else if (regAddr == EPM_REG_HOURS)
                rd = {16'h0000, state_ff.hours};
            else if (regAddr == EPM_REG_LIVE)
                rd = {22'h00_0000, state_ff.live};
            else if (regAddr >= EPM_REG_DI_BASE
                     && regAddr < EPM_REG_DI_BASE + 8'(4 * EPM_NUM_DI)
                     && regAddr[1:0] == 2'b00)
            begin
                diIdx = (regAddr - EPM_REG_DI_BASE) >> 2;
                rd = {state_ff.diDelay[diIdx], state_ff.diFunc[diIdx]};
            end
        end
        nxt_state.rdata = rd;
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            state_ff <= '0;
        else
            state_ff <= nxt_state;
    end

    // Outputs
    assign regRdata = state_ff.rdata;
    assign irq = |(state_ff.status & state_ff.irqEn);
    assign anomaly.live = state_ff.live;
    assign anomaly.svcActive = state_ff.svc;
    assign anomaly.svcAction = state_ff.maintAct;
    assign anomaly.shutdownReq = |(state_ff.live & EPM_SD_MASK)
        || (state_ff.svc && state_ff.maintAct == EPM_ACT_SHUTDOWN);
    assign anomaly.prealarmReq = |(state_ff.live & EPM_PA_MASK)
        || (state_ff.svc && state_ff.maintAct == EPM_ACT_PREALARM);

endmodule : epm_monitor

// file: epm_pkg.sv
// Constants, types and field layout for the engine protection monitor.
// Assumes one 250 MHz clock and a simple strobe register port from a local master.
// Contract
// - Contact protection armed only if an input has its function and nonzero delay.
// - Engine protections armed after fuel solenoid opens, not during start or stop.
// - Contact trips after uninterrupted activity for its delay, counted after time mask.
// - Coolant shutdown trips at or above level for delay after mask; zero disables.
// - Oil temperature shutdown trips at or above level for delay after mask.
// - Low battery pre-alarm when strictly below level for delay; zero disables.
// - High battery pre-alarm when strictly above level for delay; zero disables.
// - Battery pre-alarms always armed except while starter motor is active; the code also requires manual or automatic mode.
// - At power-on and entry to off, nominal is 12 V below 17 V, else 24 V.
// - Battery levels are percentages of the detected nominal voltage.
// - Service anomaly when running hours since interval write reach it; zero disables.
// - Service anomaly survives power loss; cleared only by writing the interval.
// - Maintenance interval and action writes need installer access level.
// - Oil pressure shutdown trips at or below level for delay after mask.
// - Oil pressure pre-alarm trips at or below level for delay after mask.
// - Measurement protections armed only when their measurement is available.
// - Protections evaluated only in manual or automatic mode.
// - Function codes 4232 coolant shutdown, 4221 oil shutdown, 4222 oil pre-alarm.
package epm_pkg;

    localparam int EPM_NUM_DI = 4;
    localparam int EPM_AW = 8;
    localparam int EPM_DW = 16;

    // Timing: delays and masks count one-second ticks
    localparam int EPM_CLK_NS = 4;
    localparam int EPM_TICK_S = 1;
    localparam int EPM_SEC_CYCLES = EPM_TICK_S * 1000000000 / EPM_CLK_NS;
    localparam int EPM_SEC_PER_HOUR = 3600;

    // Register byte offsets
    localparam logic [7:0] EPM_REG_CTRL = 8'h00;
    localparam logic [7:0] EPM_REG_TMASK = 8'h04;
    localparam logic [7:0] EPM_REG_COOL_SD = 8'h08;
    localparam logic [7:0] EPM_REG_OILT_SD = 8'h0C;
    localparam logic [7:0] EPM_REG_OILP_SD = 8'h10;
    localparam logic [7:0] EPM_REG_OILP_PA = 8'h14;
    localparam logic [7:0] EPM_REG_BAT_LO = 8'h18;
    localparam logic [7:0] EPM_REG_BAT_HI = 8'h1C;
    localparam logic [7:0] EPM_REG_MAINT_INT = 8'h20;
    localparam logic [7:0] EPM_REG_MAINT_ACT = 8'h24;
    localparam logic [7:0] EPM_REG_STATUS = 8'h28;
    localparam logic [7:0] EPM_REG_IRQ_CLR = 8'h2C;
    localparam logic [7:0] EPM_REG_IRQ_EN = 8'h30;
    localparam logic [7:0] EPM_REG_HOURS = 8'h34;
    localparam logic [7:0] EPM_REG_LIVE = 8'h38;
    localparam logic [7:0] EPM_REG_DI_BASE = 8'h40;

    // Field positions: level/delay registers hold level in [15:0], delay in [31:16]
    localparam int EPM_LVL_LSB = 0;
    localparam int EPM_DLY_LSB = 16;
    localparam int EPM_CTRL_INSTALLER = 0;
    localparam int EPM_ST_NOM24 = 16;
    localparam int EPM_ST_MASKDONE = 17;
    localparam int EPM_ST_SVC = 18;

    // Digital input function codes
    localparam logic [15:0] EPM_FN_COOL_SD = 16'h1088;
    localparam logic [15:0] EPM_FN_OILP_SD = 16'h107D;
    localparam logic [15:0] EPM_FN_OILP_PA = 16'h107E;

    // Battery figures in millivolts, and the percent scale factor
    localparam logic [31:0] EPM_BAT_SPLIT_MV = 32'h4268;
    localparam logic [31:0] EPM_NOM12_MV = 32'h2EE0;
    localparam logic [31:0] EPM_NOM24_MV = 32'h5DC0;
    localparam logic [31:0] EPM_PCT_SCALE = 32'h64;

    // Event bit positions
    localparam int EPM_EV_COOL_CT = 0;
    localparam int EPM_EV_COOL_MS = 1;
    localparam int EPM_EV_OILT_MS = 2;
    localparam int EPM_EV_OPSD_CT = 3;
    localparam int EPM_EV_OPSD_MS = 4;
    localparam int EPM_EV_OPPA_CT = 5;
    localparam int EPM_EV_OPPA_MS = 6;
    localparam int EPM_EV_BAT_LO = 7;
    localparam int EPM_EV_BAT_HI = 8;
    localparam int EPM_EV_SVC = 9;
    localparam int EPM_NUM_EV = 10;
    localparam logic [9:0] EPM_SD_MASK = 10'h01F;
    localparam logic [9:0] EPM_PA_MASK = 10'h1E0;

    // Measurement timers
    localparam int EPM_TM_COOL = 0;
    localparam int EPM_TM_OILT = 1;
    localparam int EPM_TM_OPSD = 2;
    localparam int EPM_TM_OPPA = 3;
    localparam int EPM_TM_BLO = 4;
    localparam int EPM_TM_BHI = 5;
    localparam int EPM_NUM_TM = 6;

    typedef enum logic [1:0] {
        EPM_MODE_OFF = 2'b00,
        EPM_MODE_MAN = 2'b01,
        EPM_MODE_AUTO = 2'b11,
        EPM_MODE_TEST = 2'b10
    } epm_mode_e;

    typedef enum logic [1:0] {
        EPM_ACT_SHUTDOWN = 2'b00,
        EPM_ACT_PREALARM = 2'b01,
        EPM_ACT_WARNING = 2'b11,
        EPM_ACT_NONE = 2'b10
    } epm_act_e;

    // Engine status from the sequencer
    typedef struct packed {
        logic fuelOpen;
        logic startPhase;
        logic stopPhase;
        logic running;
        logic starterOn;
    } epm_eng_s;

    // Measurements with availability flags
    typedef struct packed {
        logic coolAvail;
        logic oiltAvail;
        logic oilpAvail;
        logic [15:0] coolTemp;
        logic [15:0] oilTemp;
        logic [15:0] oilPress;
        logic [15:0] batMv;
    } epm_meas_s;

    typedef struct packed {
        logic shutdownReq;
        logic prealarmReq;
        logic svcActive;
        epm_act_e svcAction;
        logic [EPM_NUM_EV-1:0] live;
    } epm_anom_s;

endpackage : epm_pkg

// file: epm_plant.sv
// Engine sequencer stand-in: cranks for three cycles, then runs with fuel open.
// Assumes the bench drives run on sys_clk; drops back to stopped when run falls.
`timescale 1ns/1ps
module epm_plant
    import epm_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Command
    input wire logic run,
    // Engine status
    output epm_eng_s engine
);
    logic [1:0] crankCnt;

    always_ff @(posedge sys_clk)
        crankCnt <= run ? ((crankCnt == 2'h3) ? crankCnt : crankCnt + 2'h1) : 2'h0;

    // Starter runs for the whole start phase
    always_comb
    begin
        engine = '0;
        engine.fuelOpen = run;
        engine.startPhase = run && (crankCnt != 2'h3);
        engine.starterOn = engine.startPhase;
        engine.running = run && (crankCnt == 2'h3);
    end
endmodule : epm_plant

// file: epm_chk_monitor.sv
// Port checker for the engine protection monitor.
// Assumes binding onto epm_monitor; sees its ports only.
`timescale 1ns/1ps
module epm_chk
    import epm_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Register port
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdata,
    // Plant and anomaly side
    input wire epm_mode_e opMode,
    input wire epm_eng_s engine,
    input wire epm_meas_s meas,
    input wire epm_anom_s anomaly,
    input wire logic irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    chk_rdata_idle: assert property (!$past(regRd) |-> regRdata == 32'h0)
        else $error("read data outside its slot");
    chk_shutdown_merge: assert property (
        |(anomaly.live & EPM_SD_MASK) |-> anomaly.shutdownReq)
        else $error("shutdown event without request");
    chk_prealarm_merge: assert property (
        |(anomaly.live & EPM_PA_MASK) |-> anomaly.prealarmReq)
        else $error("pre-alarm event without request");
    chk_mode_gate: assert property (
        !(opMode inside {EPM_MODE_MAN, EPM_MODE_AUTO}) [*2] |-> !anomaly.live[8:0])
        else $error("protection live outside its modes");
    chk_starter_hold: assert property (engine.starterOn [*2] |-> !anomaly.live[8:7])
        else $error("battery event while starter on");
    chk_fuel_arm: assert property (
        (!engine.fuelOpen || engine.startPhase || engine.stopPhase) [*2] |-> !anomaly.live[6:0])
        else $error("engine protection live while disarmed");
    chk_avail_gate: assert property (!meas.coolAvail [*2] |-> !anomaly.live[1])
        else $error("coolant event without measurement");
    chk_irq_drop: assert property ($fell(irq) |-> $past(regWr))
        else $error("interrupt fell without a write");

    cover property (anomaly.shutdownReq);
    cover property (anomaly.prealarmReq && irq);
    cover property (anomaly.svcActive);
endmodule : epm_chk

// file: epm_tb.sv
// Self-checking bench for the engine protection monitor.
// Assumes a short second and hour; the plant model drives the engine.
`timescale 1ns/1ps
module testbench
    import epm_pkg::*;
;
    localparam int SC = 10;
    logic sys_clk = 1'b0, reset = 1'b1, regWr = 1'b0, regRd = 1'b0, run = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0, regRdata;
    logic [3:0] contactPin = 4'h0;
    epm_mode_e opMode = EPM_MODE_MAN;
    epm_eng_s engine;
    epm_meas_s meas = '{1'b1, 1'b1, 1'b1, 16'h0, 16'h0, 16'h00C8, 16'h2EE0};
    epm_anom_s anomaly;
    logic irq;
    int errorCnt = 0, comparisons = 0, cyc = 0;

    epm_monitor #(.SEC_CYCLES(SC), .SEC_PER_HOUR(3)) u_epm_monitor (.sys_clk(sys_clk),
        .reset(reset), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .contactPin(contactPin), .opMode(opMode), .engine(engine),
        .meas(meas), .svcRestore(1'b0), .anomaly(anomaly), .irq(irq));
    epm_plant u_epm_plant (.sys_clk(sys_clk), .run(run), .engine(engine));

    initial forever #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
        if (++cyc == 20000)
        begin
            errorCnt++;
            finish_test();
        end

    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask : wr
    task rd(input string name, input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1 check(name, exp, regRdata);
    endtask : rd
    // Trip must land in [lo, hi]: early means the delay was skipped
    task waitLive(input string name, input int b, input int lo, input int hi);
        int n;
        n = 0;
        while (anomaly.live[b] !== 1'b1 && n <= hi)
        begin
            @(posedge sys_clk);
            #1 n++;
        end
        check(name, 32'h1, 32'((n >= lo) && (n <= hi)));
    endtask : waitLive
    task finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, errorCnt);
        if (errorCnt == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test

    initial
    begin
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        rd("status", EPM_REG_STATUS, 32'h20000);
        rd("unmapped", 8'h3C, 32'h0);
        wr(EPM_REG_TMASK, 32'h2);
        wr(EPM_REG_IRQ_EN, 32'h3FF);
        wr(EPM_REG_DI_BASE, {16'h3, EPM_FN_COOL_SD});
        wr(EPM_REG_DI_BASE + 8'h4, {16'h0, EPM_FN_OILP_SD});
        wr(EPM_REG_DI_BASE + 8'h8, {16'h3, EPM_FN_OILP_PA});
        wr(EPM_REG_COOL_SD, 32'h0002005A);
        wr(EPM_REG_OILP_SD, 32'h00020064);
        wr(EPM_REG_BAT_LO, 32'h0002005A);
        wr(EPM_REG_BAT_HI, 32'h0002006E);
        run <= 1'b1;
        repeat (4)
        begin
            contactPin <= 4'h7;
            repeat (15) @(posedge sys_clk);
            contactPin <= 4'h0;
            @(posedge sys_clk);
        end
        check("brokenContact", 32'h0, 32'(anomaly.live[5:0]));
        contactPin <= 4'h7;
        waitLive("coolCt", EPM_EV_COOL_CT, 2 * SC, 3 * SC + 10);
        #(4 * SC) check("contacts", 32'h21, 32'(anomaly.live[5:0]));
        check("reqs", 32'h3, 32'({anomaly.shutdownReq, anomaly.prealarmReq}));
        $display("contact test done");
        @(posedge sys_clk) meas.coolTemp <= 16'h005A;
        meas.oilPress <= 16'h0064;
        waitLive("coolMs", EPM_EV_COOL_MS, SC, 2 * SC + 6);
        #(2 * SC) check("oilpMs", 32'h1, 32'(anomaly.live[EPM_EV_OPSD_MS]));
        @(posedge sys_clk) meas.batMv <= 16'(EPM_NOM12_MV * 90 / EPM_PCT_SCALE - 1);
        waitLive("batLo", EPM_EV_BAT_LO, SC, 2 * SC + 6);
        @(posedge sys_clk) meas.batMv <= 16'(EPM_NOM12_MV * 110 / EPM_PCT_SCALE);
        #(4 * SC + 1) check("batAtLevel", 32'h0, 32'(anomaly.live[EPM_EV_BAT_HI]));
        @(posedge sys_clk) meas.batMv <= 16'(EPM_NOM12_MV * 110 / EPM_PCT_SCALE + 1);
        waitLive("batHi", EPM_EV_BAT_HI, SC, 2 * SC + 6);
        $display("measure test done");
        rd("sticky", EPM_REG_STATUS, 32'h201B3);
        check("irqOn", 32'h1, 32'(irq));
        wr(EPM_REG_IRQ_EN, 32'h0);
        #1 check("irqMasked", 32'h0, 32'(irq));
        wr(EPM_REG_IRQ_CLR, 32'h3FF);
        wr(EPM_REG_IRQ_EN, 32'h3FF);
        #1 check("irqCleared", 32'h0, 32'(irq));
        $display("interrupt test done");
        @(posedge sys_clk) opMode <= EPM_MODE_OFF;
        meas.batMv <= 16'(EPM_NOM24_MV);
        meas.coolAvail <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rd("nominal24", EPM_REG_STATUS, 32'h30000);
        check("offLive", 32'h0, 32'(anomaly.live));
        $display("mode test done");
        @(posedge sys_clk) opMode <= EPM_MODE_MAN;
        wr(EPM_REG_MAINT_INT, 32'h2);
        rd("guarded", EPM_REG_MAINT_INT, 32'h0);
        wr(EPM_REG_CTRL, 32'h1);
        wr(EPM_REG_MAINT_ACT, 32'(EPM_ACT_PREALARM));
        wr(EPM_REG_MAINT_INT, 32'h2);
        waitLive("svc", EPM_EV_SVC, 4 * SC, 7 * SC + 10);
        check("svcAct", 32'(EPM_ACT_PREALARM), 32'(anomaly.svcAction));
        wr(EPM_REG_MAINT_INT, 32'h2);
        #1 check("svcCleared", 32'h0, 32'(anomaly.svcActive));
        $display("service test done");
        finish_test();
    end
endmodule : testbench

bind epm_monitor epm_chk u_epm_chk (.sys_clk(sys_clk), .reset(reset), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .opMode(opMode), .engine(engine), .meas(meas),
    .anomaly(anomaly), .irq(irq));
